// ==== rtl/pbc_pkg.sv ====
// Shared constants and types for the basic_phy_control block
package pbc_pkg;

  // Register address on the management bus
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;

  // Bit positions in the control word
  localparam int BIT_SOFT_RESET   = 15;
  localparam int BIT_LOOPBACK     = 14;
  localparam int BIT_SPEED_LSB    = 13;
  localparam int BIT_AUTONEG_EN   = 12;
  localparam int BIT_POWER_DOWN   = 11;
  localparam int BIT_ISOLATE      = 10;
  localparam int BIT_NEG_RESTART  = 9;
  localparam int BIT_DUPLEX       = 8;
  localparam int BIT_COL_TEST     = 7;
  localparam int BIT_SPEED_MSB    = 6;

  // Values after reset
  localparam logic RST_LOOPBACK   = 1'b0;
  localparam logic RST_SPEED_LSB  = 1'b0;
  localparam logic RST_AUTONEG_EN = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_ISOLATE    = 1'b0;
  localparam logic RST_DUPLEX     = 1'b1;
  localparam logic RST_COL_TEST   = 1'b0;
  localparam logic RST_SPEED_MSB  = 1'b1;
  localparam logic [5:0] RESERVED_READ = 6'h00;

  // Management frame codes
  localparam logic [1:0] OP_READ  = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [3:0] OP_LAST  = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST = 4'hf;

  // Timing
  localparam int MDC_MAX_KHZ      = 12500;
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int SOFT_RESET_NS    = 1000;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum {
    FRM_IDLE,
    FRM_START,
    FRM_OP,
    FRM_ADDR,
    FRM_TA,
    FRM_DATA
  } pbc_frame_t;

endpackage : pbc_pkg

// ==== rtl/pbc_sync.sv ====
// Two-flop synchroniser for inputs from outside the ref_clk domain
`timescale 1ns/1ps
module pbc_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule : pbc_sync

// ==== rtl/pbc_basic_control.sv ====
// Management frame engine and basic_phy_control of the transceiver
`timescale 1ns/1ps

// Overview of operation
// RULE1: Master keeps MDC at or below 12.5 MHz
// RULE2: Register bits move serially, timed by MDC
// RULE3: Bit 15 soft reset, clears itself when done
// RULE4: Bit 14 enables internal loopback, default off
// RULE5: Bits 6,13 pick speed when negotiation off
// RULE6: Bit 8 duplex, manual only, default full
// RULE7: Bit 12 enables negotiation, default on
// RULE8: Bit 11 power down; leaving it restarts negotiation
// RULE9: Bit 10 isolates: ignore TX, float RX
// RULE10: Bit 9 restarts negotiation, self clears; resets too
// RULE11: Bit 7 echoes transmit enable onto collision
// RULE12: Bits 5..0 reserved, written zero, read zero
// RULE13: Soft reset restores loopback, powerdown, isolate, coltest
module pbc_basic_control
#(
  parameter logic [4:0] PHY_ADDR         = 5'h00,
  parameter int         SOFT_RESET_COUNT = pbc_pkg::SOFT_RESET_CYCLES
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       mdcPin,
  input  wire logic       mdioIn,
  output logic            mdioOut,
  output logic            mdioOe,
  input  wire logic       txEnPin,
  input  wire logic [3:0] txdPin,
  output logic            txEnCore,
  output logic [3:0]      txdCore,
  input  wire logic       coreRxDv,
  input  wire logic [3:0] coreRxd,
  input  wire logic       coreCol,
  output logic            rxDvOut,
  output logic [3:0]      rxdOut,
  output logic            rxOe,
  output logic            colOut,
  output logic            loopbackEn,
  output logic [1:0]      manualSpeed,
  output logic            fullDuplex,
  output logic            autoNegEn,
  output logic            powerDown,
  output logic            isolate,
  output logic            softResetBusy,
  output logic            negotiationRestart
);

  localparam int RCW = $clog2(SOFT_RESET_COUNT + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] mgmtSync;
  logic [4:0] txSync;

  pbc_sync #(.WIDTH(2)) uMgmtSync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn ({mdcPin, mdioIn}),
    .syncOut (mgmtSync)
  );

  pbc_sync #(.WIDTH(5)) uTxSync
  (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn ({txEnPin, txdPin}),
    .syncOut (txSync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Management frame engine
  pbc_pkg::pbc_frame_t state_reg, state_next;
  logic        mdcPrev_reg;
  logic [3:0]  cnt_reg, cnt_next;
  logic [1:0]  opCode_reg, opCode_next;
  logic        phyHit_reg, phyHit_next;
  logic        regHit_reg, regHit_next;
  logic [15:0] shift_reg, shift_next;
  logic        mdioOut_reg, mdioOut_next;
  logic        mdioOe_reg, mdioOe_next;
  logic        wrStrobe_reg, wrStrobe_next;
  logic [15:0] wrData_reg, wrData_next;
  logic        mdcRise;
  logic        bitIn;
  logic        isRead;
  logic [15:0] ctrlWord;
  logic [15:0] readWord;
  logic [9:0]  addrBits;

  assign mdcRise  = mgmtSync[1] & ~mdcPrev_reg;
  assign bitIn    = mgmtSync[0];
  assign isRead   = (opCode_reg == pbc_pkg::OP_READ);
  assign readWord = regHit_reg ? ctrlWord : 16'h0000;
  assign addrBits = {shift_reg[8:0], bitIn};

  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    opCode_next   = opCode_reg;
    phyHit_next   = phyHit_reg;
    regHit_next   = regHit_reg;
    shift_next    = shift_reg;
    mdioOut_next  = mdioOut_reg;
    mdioOe_next   = mdioOe_reg;
    wrStrobe_next = 1'b0;
    wrData_next   = wrData_reg;
    if (mdcRise)                                                  // [RULE2]
    begin
      case (state_reg)
        pbc_pkg::FRM_IDLE:
        begin
          mdioOe_next = 1'b0;
          if (!bitIn)
            state_next = pbc_pkg::FRM_START;
        end
        pbc_pkg::FRM_START:
        begin
          cnt_next   = 4'h0;
          state_next = bitIn ? pbc_pkg::FRM_OP : pbc_pkg::FRM_IDLE;
        end
        pbc_pkg::FRM_OP:
        begin
          shift_next = {shift_reg[14:0], bitIn};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == pbc_pkg::OP_LAST)
          begin
            opCode_next = {shift_reg[0], bitIn};
            cnt_next    = 4'h0;
            state_next  = pbc_pkg::FRM_ADDR;
          end
        end
        pbc_pkg::FRM_ADDR:
        begin
          shift_next = {shift_reg[14:0], bitIn};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == pbc_pkg::ADDR_LAST)
          begin
            phyHit_next = (addrBits[9:5] == PHY_ADDR);
            regHit_next = (addrBits[4:0] == pbc_pkg::REG_BASIC_CONTROL);
            cnt_next    = 4'h0;
            if (opCode_reg == pbc_pkg::OP_READ || opCode_reg == pbc_pkg::OP_WRITE)
              state_next = pbc_pkg::FRM_TA;
            else
              state_next = pbc_pkg::FRM_IDLE;
          end
        end
        pbc_pkg::FRM_TA:
        begin
          if (cnt_reg == 4'h0)
          begin
            cnt_next = 4'h1;
            if (isRead && phyHit_reg)
            begin
              mdioOe_next  = 1'b1;
              mdioOut_next = 1'b0;
            end
          end
          else
          begin
            cnt_next     = 4'h0;
            state_next   = pbc_pkg::FRM_DATA;
            mdioOut_next = readWord[15];
            shift_next   = {readWord[14:0], 1'b0};
          end
        end
        pbc_pkg::FRM_DATA:
        begin
          cnt_next = cnt_reg + 4'h1;
          if (isRead)
          begin
            mdioOut_next = shift_reg[15];
            shift_next   = {shift_reg[14:0], 1'b0};
          end
          else
            shift_next = {shift_reg[14:0], bitIn};
          if (cnt_reg == pbc_pkg::DATA_LAST)
          begin
            mdioOe_next   = 1'b0;
            state_next    = pbc_pkg::FRM_IDLE;
            wrData_next   = {shift_reg[14:0], bitIn};
            wrStrobe_next = !isRead && phyHit_reg && regHit_reg;
          end
        end
        default:
        begin
          state_next  = pbc_pkg::FRM_IDLE;
          mdioOe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg    <= pbc_pkg::FRM_IDLE;
      mdcPrev_reg  <= 1'b0;
      cnt_reg      <= 4'h0;
      opCode_reg   <= 2'h0;
      phyHit_reg   <= 1'b0;
      regHit_reg   <= 1'b0;
      shift_reg    <= 16'h0000;
      mdioOut_reg  <= 1'b0;
      mdioOe_reg   <= 1'b0;
      wrStrobe_reg <= 1'b0;
      wrData_reg   <= 16'h0000;
    end
    else
    begin
      state_reg    <= state_next;
      mdcPrev_reg  <= mgmtSync[1];
      cnt_reg      <= cnt_next;
      opCode_reg   <= opCode_next;
      phyHit_reg   <= phyHit_next;
      regHit_reg   <= regHit_next;
      shift_reg    <= shift_next;
      mdioOut_reg  <= mdioOut_next;
      mdioOe_reg   <= mdioOe_next;
      wrStrobe_reg <= wrStrobe_next;
      wrData_reg   <= wrData_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  logic           loop_reg, loop_next;
  logic           spdLsb_reg, spdLsb_next;
  logic           anEn_reg, anEn_next;
  logic           pwrDn_reg, pwrDn_next;
  logic           iso_reg, iso_next;
  logic           dup_reg, dup_next;
  logic           colTst_reg, colTst_next;
  logic           spdMsb_reg, spdMsb_next;
  logic           rstBusy_reg, rstBusy_next;
  logic [RCW-1:0] rstCnt_reg, rstCnt_next;
  logic           startup_reg;
  logic           restart_reg, restart_next;

  assign ctrlWord = {rstBusy_reg, loop_reg, spdLsb_reg, anEn_reg, pwrDn_reg, iso_reg,
                     1'b0, dup_reg, colTst_reg, spdMsb_reg,
                     pbc_pkg::RESERVED_READ};                     // [RULE12] [RULE10]

  always_comb
  begin
    loop_next    = loop_reg;
    spdLsb_next  = spdLsb_reg;
    anEn_next    = anEn_reg;
    pwrDn_next   = pwrDn_reg;
    iso_next     = iso_reg;
    dup_next     = dup_reg;
    colTst_next  = colTst_reg;
    spdMsb_next  = spdMsb_reg;
    rstBusy_next = rstBusy_reg;
    rstCnt_next  = rstCnt_reg;
    restart_next = startup_reg;                                   // [RULE10]
    if (rstBusy_reg)
    begin
      if (rstCnt_reg == '0)
      begin
        rstBusy_next = 1'b0;                                      // [RULE3]
        restart_next = 1'b1;                                      // [RULE10]
      end
      else
        rstCnt_next = rstCnt_reg - RCW'(1);
    end
    if (wrStrobe_reg)
    begin
      loop_next   = wrData_reg[pbc_pkg::BIT_LOOPBACK];            // [RULE4]
      spdLsb_next = wrData_reg[pbc_pkg::BIT_SPEED_LSB];           // [RULE5]
      anEn_next   = wrData_reg[pbc_pkg::BIT_AUTONEG_EN];          // [RULE7]
      pwrDn_next  = wrData_reg[pbc_pkg::BIT_POWER_DOWN];
      iso_next    = wrData_reg[pbc_pkg::BIT_ISOLATE];             // [RULE9]
      dup_next    = wrData_reg[pbc_pkg::BIT_DUPLEX];              // [RULE6]
      colTst_next = wrData_reg[pbc_pkg::BIT_COL_TEST];            // [RULE11]
      spdMsb_next = wrData_reg[pbc_pkg::BIT_SPEED_MSB];           // [RULE5]
      if (wrData_reg[pbc_pkg::BIT_NEG_RESTART])
        restart_next = 1'b1;                                      // [RULE10]
      if (pwrDn_reg && !wrData_reg[pbc_pkg::BIT_POWER_DOWN])
        restart_next = 1'b1;                                      // [RULE8]
      if (wrData_reg[pbc_pkg::BIT_SOFT_RESET])
      begin
        rstBusy_next = 1'b1;                                      // [RULE3]
        rstCnt_next  = RCW'(SOFT_RESET_COUNT);
        loop_next    = pbc_pkg::RST_LOOPBACK;                     // [RULE13]
        pwrDn_next   = pbc_pkg::RST_POWER_DOWN;                   // [RULE13]
        iso_next     = pbc_pkg::RST_ISOLATE;                      // [RULE13]
        colTst_next  = pbc_pkg::RST_COL_TEST;                     // [RULE13]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop_reg    <= pbc_pkg::RST_LOOPBACK;
      spdLsb_reg  <= pbc_pkg::RST_SPEED_LSB;
      anEn_reg    <= pbc_pkg::RST_AUTONEG_EN;
      pwrDn_reg   <= pbc_pkg::RST_POWER_DOWN;
      iso_reg     <= pbc_pkg::RST_ISOLATE;
      dup_reg     <= pbc_pkg::RST_DUPLEX;
      colTst_reg  <= pbc_pkg::RST_COL_TEST;
      spdMsb_reg  <= pbc_pkg::RST_SPEED_MSB;
      rstBusy_reg <= 1'b0;
      rstCnt_reg  <= '0;
      startup_reg <= 1'b1;
      restart_reg <= 1'b0;
    end
    else
    begin
      loop_reg    <= loop_next;
      spdLsb_reg  <= spdLsb_next;
      anEn_reg    <= anEn_next;
      pwrDn_reg   <= pwrDn_next;
      iso_reg     <= iso_next;
      dup_reg     <= dup_next;
      colTst_reg  <= colTst_next;
      spdMsb_reg  <= spdMsb_next;
      rstBusy_reg <= rstBusy_next;
      rstCnt_reg  <= rstCnt_next;
      startup_reg <= 1'b0;
      restart_reg <= restart_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // MII pin handling
  logic       txEnC_reg, txEnC_next;
  logic [3:0] txdC_reg, txdC_next;
  logic       rxDv_reg, rxDv_next;
  logic [3:0] rxd_reg, rxd_next;
  logic       rxOe_reg, rxOe_next;
  logic       col_reg, col_next;

  always_comb
  begin
    txEnC_next = txSync[4] & ~iso_reg;                            // [RULE9]
    txdC_next  = iso_reg ? 4'h0 : txSync[3:0];                    // [RULE9]
    rxDv_next  = loop_reg ? txEnC_reg : coreRxDv;                 // [RULE4]
    rxd_next   = loop_reg ? txdC_reg : coreRxd;                   // [RULE4]
    rxOe_next  = ~iso_reg;                                        // [RULE9]
    col_next   = coreCol | (colTst_reg & txEnC_reg);              // [RULE11]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txEnC_reg <= 1'b0;
      txdC_reg  <= 4'h0;
      rxDv_reg  <= 1'b0;
      rxd_reg   <= 4'h0;
      rxOe_reg  <= 1'b0;
      col_reg   <= 1'b0;
    end
    else
    begin
      txEnC_reg <= txEnC_next;
      txdC_reg  <= txdC_next;
      rxDv_reg  <= rxDv_next;
      rxd_reg   <= rxd_next;
      rxOe_reg  <= rxOe_next;
      col_reg   <= col_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign mdioOut            = mdioOut_reg;
  assign mdioOe             = mdioOe_reg;
  assign txEnCore           = txEnC_reg;
  assign txdCore            = txdC_reg;
  assign rxDvOut            = rxDv_reg;
  assign rxdOut             = rxd_reg;
  assign rxOe               = rxOe_reg;
  assign colOut             = col_reg;
  assign loopbackEn         = loop_reg;
  assign manualSpeed        = {spdMsb_reg, spdLsb_reg};
  assign fullDuplex         = dup_reg;
  assign autoNegEn          = anEn_reg;
  assign powerDown          = pwrDn_reg;
  assign isolate            = iso_reg;
  assign softResetBusy      = rstBusy_reg;
  assign negotiationRestart = restart_reg;

endmodule : pbc_basic_control

// ==== testbench/pbc_basic_control_checker.sv ====
// Port assertions for the basic_phy_control block
`timescale 1ns/1ps
module pbc_basic_control_checker
#(
  parameter int SOFT_RESET_COUNT = 40
)
(
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       mdioOut,
  input wire logic       mdioOe,
  input wire logic       txEnCore,
  input wire logic [3:0] txdCore,
  input wire logic       coreRxDv,
  input wire logic [3:0] coreRxd,
  input wire logic       coreCol,
  input wire logic       rxDvOut,
  input wire logic [3:0] rxdOut,
  input wire logic       rxOe,
  input wire logic       colOut,
  input wire logic       loopbackEn,
  input wire logic       powerDown,
  input wire logic       isolate,
  input wire logic       softResetBusy,
  input wire logic       negotiationRestart
);
  localparam int SR_LO = SOFT_RESET_COUNT;
  localparam int SR_HI = SOFT_RESET_COUNT + 2;
  localparam int PD_HI = SOFT_RESET_COUNT + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  AST_TX_BLOCKED:
    assert property (isolate ##1 isolate |-> !txEnCore && txdCore == 4'h0)
    else $error("transmit passed while isolated");
  AST_RX_FLOAT:
    assert property (isolate ##1 isolate |-> !rxOe)
    else $error("receive pins driven while isolated");
  AST_RX_DRIVE:
    assert property (!isolate ##1 !isolate && $past(reset_n) |-> rxOe)
    else $error("receive pins floating while not isolated");
  AST_COL_CAUSE:
    assert property (colOut |-> $past(coreCol) || $past(txEnCore))
    else $error("collision without a cause");
  AST_LOOP_MUX:
    assert property ({rxDvOut, rxdOut} == ($past(loopbackEn) ? {$past(txEnCore),
      $past(txdCore)} : {$past(coreRxDv), $past(coreRxd)}))
    else $error("receive path source wrong");
  AST_SR_LEN:
    assert property ($rose(softResetBusy) |-> ##[SR_LO:SR_HI] $fell(softResetBusy))
    else $error("soft reset length wrong");
  AST_SR_CLEAR:
    assert property ($rose(softResetBusy) |-> !loopbackEn && !powerDown && !isolate)
    else $error("soft reset left fields set");
  AST_SR_RESTART:
    assert property ($fell(softResetBusy) |-> ##[0:1] negotiationRestart)
    else $error("no restart after soft reset");
  AST_PD_RESTART:
    assert property ($fell(powerDown) |-> ##[0:PD_HI] negotiationRestart)
    else $error("no restart on leaving power down");
  AST_RESTART_PULSE:
    assert property (negotiationRestart |=> !negotiationRestart)
    else $error("restart longer than one cycle");
  AST_TA_LOW:
    assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround not driven low");
endmodule : pbc_basic_control_checker

bind pbc_basic_control pbc_basic_control_checker
  #(.SOFT_RESET_COUNT(SOFT_RESET_COUNT)) chk_i (.*);

// ==== testbench/pbc_mdio_master.sv ====
// Behavioural management master clocking frames onto the serial bus
`timescale 1ns/1ps
module pbc_mdio_master
(
  output logic      mdcPin,
  output logic      mdioIn,
  input  wire logic mdioOut,
  input  wire logic mdioOe
);
  logic mBit;
  logic mOe;
  // Pull-up holds the released line high
  assign mdioIn = mdioOe ? mdioOut : (mOe ? mBit : 1'b1);
  initial
  begin
    mdcPin = 1'b0;
    mBit   = 1'b1;
    mOe    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame, 200 ns per bit, clock idle low between frames
  task automatic frame(
    input  logic [1:0]  op,
    input  logic [4:0]  phy,
    input  logic [4:0]  ra,
    input  logic [15:0] wd,
    output logic [15:0] rd
  );
    logic [31:0] sh;
    sh = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    #7;
    for (int i = 0; i < 33; i++)
    begin
      mOe = (op == pbc_pkg::OP_READ) ? (i < 14) : (i < 32);
      mBit = (i < 32) ? sh[31 - i] : 1'b1;
      #100 mdcPin = 1'b1;
      if (i >= 16 && i < 32)
        rd = {rd[14:0], mdioIn};
      #100 mdcPin = 1'b0;
    end
    mOe = 1'b0;
  endtask : frame
endmodule : pbc_mdio_master

// ==== testbench/pbc_basic_control_tb.sv ====
// Self-checking bench for the basic_phy_control block
`timescale 1ns/1ps
module pbc_basic_control_tb;
  logic        ref_clk, reset_n, mdcPin, mdioIn, mdioOut, mdioOe, txEnPin, txEnCore;
  logic        coreRxDv, coreCol, rxDvOut, rxOe, colOut, loopbackEn, fullDuplex;
  logic        autoNegEn, powerDown, isolate, softResetBusy, negotiationRestart;
  logic [1:0]  manualSpeed;
  logic [3:0]  txdPin, txdCore, coreRxd, rxdOut;
  logic [15:0] w, v;
  int          n_fail;
  int          total_checks;

  pbc_basic_control #(.SOFT_RESET_COUNT(3)) uut (.*);
  pbc_mdio_master mst (.mdcPin(mdcPin), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (reset_n)
    begin
      txdPin   <= 4'($urandom);
      coreRxd  <= 4'($urandom);
      coreRxDv <= 1'($urandom);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] expv(input logic [15:0] d);
    return d & 16'h7dc0;
  endfunction : expv
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mst.frame(pbc_pkg::OP_WRITE, 5'h00, ra, d, x);
    repeat (4) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    mst.frame(pbc_pkg::OP_READ, 5'h00, ra, 16'h0000, d);
  endtask : rd
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    void'($urandom(55602));
    n_fail = 0;
    total_checks = 0;
    reset_n = 1'b0;
    txEnPin = 1'b0;
    txdPin = 4'h0;
    coreRxDv = 1'b0;
    coreRxd = 4'h0;
    coreCol = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({autoNegEn, fullDuplex, manualSpeed, loopbackEn, powerDown, isolate}, 16'h70);
    rd(5'h00, v);
    chk(v, 16'h1140);
    // Every manual speed code with random other fields
    for (int i = 0; i < 8; i++)
    begin
      w = 16'($urandom) & 16'h7fc0;
      w[6] = i[1];
      w[13] = i[0];
      wr(5'h00, w);
      chk({loopbackEn, manualSpeed, autoNegEn, powerDown, isolate, fullDuplex},
          {w[14], w[6], w[13], w[12:10], w[8]});
      rd(5'h00, v);
      chk(v, expv(w));
    end
    // Foreign address, bad op codes and other registers leave it alone
    mst.frame(pbc_pkg::OP_WRITE, 5'h1f, 5'h00, 16'hffff, v);
    mst.frame(2'b00, 5'h1f, 5'h00, 16'hffff, v);
    mst.frame(2'b11, 5'h1f, 5'h00, 16'hffff, v);
    wr(5'h02, 16'hffff);
    rd(5'h00, v);
    chk(v, expv(w));
    mst.frame(pbc_pkg::OP_READ, 5'h1f, 5'h00, 16'h0000, v);
    chk(v, 16'hffff);
    rd(5'h02, v);
    chk(v, 16'h0000);
    wr(5'h00, 16'h0480);
    txEnPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({txEnCore, rxOe, colOut}, 16'h0);
    wr(5'h00, 16'h0080);
    chk({txEnCore, rxOe, colOut}, 16'h7);
    wr(5'h00, 16'h4000);
    chk({rxDvOut, rxOe, colOut}, 16'h6);
    wr(5'h00, 16'hdc80);
    rd(5'h00, v);
    chk(v, 16'h1000);
    chk({softResetBusy, loopbackEn, powerDown, isolate, colOut}, 16'h0);
    txEnPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(colOut, 16'h0);
    complete_run();
  end
endmodule : pbc_basic_control_tb
